/* File: verilog/spes_regs.vh */
// Register map, field positions, event codes and limits of the
// system interface performance event selector.
// Assumes inclusion by bare name from the design file.
`ifndef SPES_REGS_VH
`define SPES_REGS_VH

`define SPES_ADDR_W        8
`define SPES_OFF_CTRL      8'h00
`define SPES_OFF_CNT_LO    8'h04
`define SPES_OFF_CNT_HI    8'h08
`define SPES_OFF_INC       8'h0C

`define SPES_EVT_LSB       0
`define SPES_EVT_MSB       7
`define SPES_MASK_LSB      8
`define SPES_MASK_MSB      15
`define SPES_EN_BIT        22
`define SPES_CTRL_RST      32'h0000_0000
`define SPES_CTRL_WMASK    32'h0040_FFFF

`define SPES_EV_RX_BYPASS    8'h75
`define SPES_EV_RX_STANDARD  8'h74
`define SPES_EV_RX_NONDATA   8'h70
`define SPES_EV_RX_SNOOP     8'h71
`define SPES_EV_TX_DATARESP  8'h64
`define SPES_EV_TX_HOME      8'h60
`define SPES_EV_TX_BYPASS    8'h68
`define SPES_EV_TX_STANDARD  8'h66
`define SPES_EV_TX_NONDATA   8'h63
`define SPES_EV_TX_SNOOP     8'h62
`define SPES_EV_CREDIT_IN    8'h76
`define SPES_EV_CREDIT_OUT   8'h6A
`define SPES_EV_HOME_BYPASS  8'h50
`define SPES_EV_SNOOP_BYPASS 8'h51
`define SPES_EV_REQ_FILL     8'h31
`define SPES_EV_HA_BYPASS    8'h52
`define SPES_EV_HAQ_FULL     8'h2B
`define SPES_EV_HAQ_NE       8'h2D
`define SPES_EV_HAQ_FILL     8'h2F
`define SPES_EV_SHQ_FILL     8'h26
`define SPES_EV_BPQ_FULL     8'h21
`define SPES_EV_BPQ_NE       8'h24
`define SPES_EV_STQ_FULL     8'h22
`define SPES_EV_NDQ_FULL     8'h27
`define SPES_EV_NDQ_NE       8'h28

`define SPES_MAX_TX_BYPASS   6'h0B
`define SPES_MAX_TX_STANDARD 6'h03
`define SPES_MAX_REQ_FILL    7'h30
`define SPES_MAX_HAQ_FILL    6'h08
`define SPES_MAX_SHQ_FILL    6'h24
`define SPES_DEPTH_BPQ       3'h4
`define SPES_DEPTH_STQ       3'h4

`endif

/* File: verilog/spes_event_select.v */
// Event selection and increment logic for the performance counter of
// the system interface box, with a small register port.
// Assumes all event inputs are synchronous to clk_sys_i and already
// qualified per cycle by the surrounding traffic logic.
// Notes on behaviour
// - Rx bypass packets: one per packet
// - Rx standard packets: one per packet
// - Rx non-data responses: one per packet
// - Rx snoops: one per packet
// - Tx data responses, slice-pair summed, first only
// - Zero subevent mask counts nothing on masked events
// - Tx home packets: router, agent, or both
// - Tx bypass packets, pair summed, max 11
// - Tx standard packets, pair summed, max 3
// - Tx non-data responses: one per packet
// - Tx snoops: first spawned only
// - Credit idle flits from router
// - Credit return idle flits to router
// - Home bypass uses toward router
// - Snoop bypass: normal, big, summed
// - Request table fill, local/remote, max 48
// - Agent bypass cycles: messages or credits
// - Agent queue full, non-empty, fill to 8
// - Shared header buffer fill, classes, max 36
// - Bypass header buffer full and non-empty
// - Standard header buffer full cycles
// - Non-data header buffer full cycles
// - Non-data header buffer non-empty cycles
`timescale 1ns/100ps
`default_nettype none
`include "spes_regs.vh"

module spes_event_select #(
	parameter CNT_W = 48
) (
	input  wire                    clk_sys_i,
	input  wire                    rst_n_i,
	input  wire [`SPES_ADDR_W-1:0] reg_addr_i,
	input  wire [31:0]             reg_wdata_i,
	input  wire                    reg_wr_i,
	input  wire                    reg_rd_i,
	output reg  [31:0]             reg_rdata_o,
	input  wire                    rx_bypass_pkt_i,
	input  wire                    rx_standard_pkt_i,
	input  wire                    rx_nondata_pkt_i,
	input  wire                    rx_snoop_pkt_i,
	input  wire [3:0]              tx_dataresp_pkt_i,
	input  wire [3:0]              tx_dataresp_spawn_i,
	input  wire [1:0]              tx_home_pkt_i,
	input  wire [15:0]             tx_bypass_pkts_i,
	input  wire [7:0]              tx_standard_pkts_i,
	input  wire                    tx_nondata_pkt_i,
	input  wire                    tx_snoop_pkt_i,
	input  wire                    tx_snoop_spawn_i,
	input  wire                    router_credit_in_i,
	input  wire                    router_credit_out_i,
	input  wire                    router_home_bypass_i,
	input  wire [1:0]              router_snoop_bypass_i,
	input  wire [5:0]              reqtbl_local_fill_i,
	input  wire [5:0]              reqtbl_remote_fill_i,
	input  wire                    ha_bypass_msg_i,
	input  wire                    ha_bypass_credit_i,
	input  wire                    ringq_ha_full_i,
	input  wire [3:0]              ringq_ha_fill_i,
	input  wire [4:0]              ringq_snoop_fill_i,
	input  wire [2:0]              ringq_standard_fill_i,
	input  wire [2:0]              ringq_bypass_fill_i,
	input  wire                    ringq_nondata_full_i,
	input  wire                    ringq_nondata_nonempty_i,
	output reg  [CNT_W-1:0]        count_o,
	output reg  [5:0]              inc_o
);

	reg  [31:0] ctrl_r;
	reg  [5:0]  inc_nxt;
	reg  [CNT_W-1:0] cnt_nxt;
	reg  [31:0] rdata_nxt;

	// Only code, mask and enable are kept; other control bits read zero
	wire [7:0] evt_code = ctrl_r[`SPES_EVT_MSB:`SPES_EVT_LSB];
	wire [7:0] sub_mask = ctrl_r[`SPES_MASK_MSB:`SPES_MASK_LSB];
	wire       cnt_en   = ctrl_r[`SPES_EN_BIT];

	// Ceiling for sums that cannot outgrow their lanes; it keeps every
	// masked sum on the same lane-sum path
	localparam [5:0] NO_CEIL = 6'h3F;

	wire [3:0]  dr_first;
	wire [5:0]  dr_sum;
	wire [5:0]  home_sum;
	wire [5:0]  byp_sum;
	wire [5:0]  std_sum;
	wire [5:0]  snb_sum;
	wire [6:0]  req_clip;
	wire [5:0]  req_sum;
	wire [5:0]  haq_sum;
	wire [14:0] shq_lanes;
	wire [5:0]  shq_sum;

	// Second copy of a spawned data response is dropped before the sum
	assign dr_first = tx_dataresp_pkt_i & ~tx_dataresp_spawn_i;

	spes_lane_sum #(
		.LANES  (4),
		.LANE_W (1),
		.SUM_W  (6)
	) spes_lane_sum_dr_i (
		.lanes_i (dr_first),
		.mask_i  (sub_mask[3:0]),
		.limit_i (NO_CEIL),
		.sum_o   (dr_sum)
	);

	spes_lane_sum #(
		.LANES  (2),
		.LANE_W (1),
		.SUM_W  (6)
	) spes_lane_sum_home_i (
		.lanes_i (tx_home_pkt_i),
		.mask_i  (sub_mask[1:0]),
		.limit_i (NO_CEIL),
		.sum_o   (home_sum)
	);

	// Clamped so a misbehaving source cannot exceed the per-cycle ceiling
	spes_lane_sum #(
		.LANES  (4),
		.LANE_W (4),
		.SUM_W  (6)
	) spes_lane_sum_byp_i (
		.lanes_i (tx_bypass_pkts_i),
		.mask_i  (sub_mask[3:0]),
		.limit_i (`SPES_MAX_TX_BYPASS),
		.sum_o   (byp_sum)
	);

	spes_lane_sum #(
		.LANES  (4),
		.LANE_W (2),
		.SUM_W  (6)
	) spes_lane_sum_std_i (
		.lanes_i (tx_standard_pkts_i),
		.mask_i  (sub_mask[3:0]),
		.limit_i (`SPES_MAX_TX_STANDARD),
		.sum_o   (std_sum)
	);

	spes_lane_sum #(
		.LANES  (2),
		.LANE_W (1),
		.SUM_W  (6)
	) spes_lane_sum_snb_i (
		.lanes_i (router_snoop_bypass_i),
		.mask_i  (sub_mask[1:0]),
		.limit_i (NO_CEIL),
		.sum_o   (snb_sum)
	);

	spes_lane_sum #(
		.LANES  (2),
		.LANE_W (6),
		.SUM_W  (7)
	) spes_lane_sum_req_i (
		.lanes_i ({reqtbl_remote_fill_i, reqtbl_local_fill_i}),
		.mask_i  (sub_mask[1:0]),
		.limit_i (`SPES_MAX_REQ_FILL),
		.sum_o   (req_clip)
	);
	assign req_sum = req_clip[5:0];

	// Queue fill has no mask; a lane forced on keeps the same clamp path
	spes_lane_sum #(
		.LANES  (1),
		.LANE_W (4),
		.SUM_W  (6)
	) spes_lane_sum_haq_i (
		.lanes_i (ringq_ha_fill_i),
		.mask_i  (1'b1),
		.limit_i (`SPES_MAX_HAQ_FILL),
		.sum_o   (haq_sum)
	);

	// Narrow lanes are widened to the snoop lane so one instance serves
	assign shq_lanes = {2'h0, ringq_bypass_fill_i, 2'h0,
		ringq_standard_fill_i, ringq_snoop_fill_i};
	spes_lane_sum #(
		.LANES  (3),
		.LANE_W (5),
		.SUM_W  (6)
	) spes_lane_sum_shq_i (
		.lanes_i (shq_lanes),
		.mask_i  (sub_mask[2:0]),
		.limit_i (`SPES_MAX_SHQ_FILL),
		.sum_o   (shq_sum)
	);

	// Queue depths are fixed here; only the fill levels come in
	wire bpq_full = (ringq_bypass_fill_i >= `SPES_DEPTH_BPQ);
	wire bpq_ne   = (ringq_bypass_fill_i != 3'h0);
	wire stq_full = (ringq_standard_fill_i >= `SPES_DEPTH_STQ);

	// Amount for the selected event; masked events fall to zero on their
	// own when the mask is clear, unmasked ones ignore the mask
	always @* begin
		inc_nxt = 6'h00;
		case (evt_code)
		`SPES_EV_RX_BYPASS: begin
			inc_nxt = {5'h00, rx_bypass_pkt_i};
		end
		`SPES_EV_RX_STANDARD: begin
			inc_nxt = {5'h00, rx_standard_pkt_i};
		end
		`SPES_EV_RX_NONDATA: begin
			inc_nxt = {5'h00, rx_nondata_pkt_i};
		end
		`SPES_EV_RX_SNOOP: begin
			inc_nxt = {5'h00, rx_snoop_pkt_i};
		end
		`SPES_EV_TX_DATARESP: begin
			inc_nxt = dr_sum;
		end
		`SPES_EV_TX_HOME: begin
			inc_nxt = home_sum;
		end
		`SPES_EV_TX_BYPASS: begin
			inc_nxt = byp_sum;
		end
		`SPES_EV_TX_STANDARD: begin
			inc_nxt = std_sum;
		end
		`SPES_EV_TX_NONDATA: begin
			inc_nxt = {5'h00, tx_nondata_pkt_i};
		end
		`SPES_EV_TX_SNOOP: begin
			inc_nxt = {5'h00, tx_snoop_pkt_i & ~tx_snoop_spawn_i};
		end
		`SPES_EV_CREDIT_IN: begin
			inc_nxt = {5'h00, router_credit_in_i};
		end
		`SPES_EV_CREDIT_OUT: begin
			inc_nxt = {5'h00, router_credit_out_i};
		end
		`SPES_EV_HOME_BYPASS: begin
			inc_nxt = {5'h00, router_home_bypass_i};
		end
		`SPES_EV_SNOOP_BYPASS: begin
			inc_nxt = snb_sum;
		end
		`SPES_EV_REQ_FILL: begin
			inc_nxt = req_sum;
		end
		`SPES_EV_HA_BYPASS: begin
			inc_nxt = {5'h00, ha_bypass_msg_i | ha_bypass_credit_i};
		end
		`SPES_EV_HAQ_FULL: begin
			inc_nxt = {5'h00, ringq_ha_full_i};
		end
		`SPES_EV_HAQ_NE: begin
			inc_nxt = {5'h00, ringq_ha_fill_i != 4'h0};
		end
		`SPES_EV_HAQ_FILL: begin
			inc_nxt = haq_sum;
		end
		`SPES_EV_SHQ_FILL: begin
			inc_nxt = shq_sum;
		end
		`SPES_EV_BPQ_FULL: begin
			inc_nxt = {5'h00, bpq_full};
		end
		`SPES_EV_BPQ_NE: begin
			inc_nxt = {5'h00, bpq_ne};
		end
		`SPES_EV_STQ_FULL: begin
			inc_nxt = {5'h00, stq_full};
		end
		`SPES_EV_NDQ_FULL: begin
			inc_nxt = {5'h00, ringq_nondata_full_i};
		end
		`SPES_EV_NDQ_NE: begin
			inc_nxt = {5'h00, ringq_nondata_nonempty_i};
		end
		default: begin
			inc_nxt = 6'h00;
		end
		endcase
	end

	// A software write to a counter half wins over counting in that cycle,
	// so a preload is never disturbed by a late event
	always @* begin
		cnt_nxt = count_o;
		if (cnt_en)
			cnt_nxt = count_o + {{(CNT_W-6){1'b0}}, inc_nxt};
		if (reg_wr_i && reg_addr_i == `SPES_OFF_CNT_LO)
			cnt_nxt = {count_o[CNT_W-1:32], reg_wdata_i};
		if (reg_wr_i && reg_addr_i == `SPES_OFF_CNT_HI)
			cnt_nxt = {reg_wdata_i[CNT_W-33:0], count_o[31:0]};
	end

	// Read data is zero outside the cycle after a read, so several slaves
	// can share one OR-ed return path with no extra gating
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
			`SPES_OFF_CTRL:   rdata_nxt = ctrl_r;
			`SPES_OFF_CNT_LO: rdata_nxt = count_o[31:0];
			`SPES_OFF_CNT_HI: rdata_nxt = {{(64-CNT_W){1'b0}},
				count_o[CNT_W-1:32]};
			`SPES_OFF_INC:    rdata_nxt = {26'h0000000, inc_o};
			default:          rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_r      <= `SPES_CTRL_RST;
			count_o     <= {CNT_W{1'b0}};
			inc_o       <= 6'h00;
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			if (reg_wr_i && reg_addr_i == `SPES_OFF_CTRL)
				ctrl_r <= reg_wdata_i & `SPES_CTRL_WMASK;
			count_o     <= cnt_nxt;
			inc_o       <= cnt_en ? inc_nxt : 6'h00;
			reg_rdata_o <= rdata_nxt;
		end
	end

endmodule

// Sum of the lanes picked by the mask, held to a per-cycle ceiling.
// SUM_W must hold LANES full lanes and be at least LANE_W wide;
// no overflow is flagged.
module spes_lane_sum #(
	parameter LANES  = 4,
	parameter LANE_W = 4,
	parameter SUM_W  = 6
) (
	input  wire [LANES*LANE_W-1:0] lanes_i,
	input  wire [LANES-1:0]        mask_i,
	input  wire [SUM_W-1:0]        limit_i,
	output reg  [SUM_W-1:0]        sum_o
);

	reg     [SUM_W-1:0] raw_sum;
	reg     [SUM_W-1:0] lane_val;
	integer             k;

	always @* begin
		raw_sum  = {SUM_W{1'b0}};
		lane_val = {SUM_W{1'b0}};
		for (k = 0; k < LANES; k = k + 1) begin
			lane_val[LANE_W-1:0] = lanes_i[k*LANE_W +: LANE_W];
			if (mask_i[k]) begin
				raw_sum = raw_sum + lane_val;
			end
		end
		sum_o = (raw_sum > limit_i) ? limit_i : raw_sum;
	end

endmodule

`default_nettype wire

/* File: tb/spes_event_select_checker.sv */
// Checker for the event selector counter and register port.
// Bound into spes_event_select; mirrors the control register from writes.
`timescale 1ns/100ps
`default_nettype none
module spes_checker #(
	parameter CNT_W = 48
) (
	input wire logic             clk_sys_i,
	input wire logic             rst_n_i,
	input wire logic [7:0]       reg_addr_i,
	input wire logic [31:0]      reg_wdata_i,
	input wire logic             reg_wr_i,
	input wire logic             reg_rd_i,
	input wire logic [31:0]      reg_rdata_o,
	input wire logic [CNT_W-1:0] count_o,
	input wire logic [5:0]       inc_o
);
	logic [31:0] ctl_r;
	logic        vq_r;
	wire         cw = reg_wr_i && reg_addr_i inside {8'h04, 8'h08};
	always @(posedge clk_sys_i) begin
		vq_r <= rst_n_i;
		if (!rst_n_i)
			ctl_r <= 32'h0;
		else if (reg_wr_i && reg_addr_i == 8'h00)
			ctl_r <= reg_wdata_i & 32'h0040_FFFF;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// The counter lands one edge after its inputs, so look back one cycle
	sequence s_on(logic [7:0] c);
		vq_r && $past(ctl_r[22]) && $past(ctl_r[7:0]) == c;
	endsequence
	property p_add;
		vq_r && $past(ctl_r[22] && !cw)
			|-> count_o == $past(count_o) + CNT_W'(inc_o);
	endproperty
	a_add: assert property (p_add) else $error("counter step wrong");
	property p_off;
		vq_r && !$past(ctl_r[22]) |-> inc_o == 6'h00;
	endproperty
	a_off: assert property (p_off) else $error("count while off");
	property p_zmask;
		vq_r && $past(ctl_r[22] && ctl_r[15:8] == 8'h00 && ctl_r[7:0]
			inside {8'h64, 8'h60, 8'h68, 8'h66, 8'h51, 8'h31, 8'h26})
			|-> inc_o == 6'h00;
	endproperty
	a_zmask: assert property (p_zmask) else $error("zero mask counted");
	property p_max11;
		s_on(8'h68) |-> inc_o <= 6'h0B;
	endproperty
	a_max11: assert property (p_max11) else $error("bypass over 11");
	property p_max3;
		s_on(8'h66) |-> inc_o <= 6'h03;
	endproperty
	a_max3: assert property (p_max3) else $error("standard over 3");
	property p_max48;
		s_on(8'h31) |-> inc_o <= 6'h30;
	endproperty
	a_max48: assert property (p_max48) else $error("table over 48");
	property p_swr;
		vq_r && $past(reg_wr_i && reg_addr_i == 8'h04)
			|-> count_o[31:0] == $past(reg_wdata_i);
	endproperty
	a_swr: assert property (p_swr) else $error("write lost");
	property p_rd;
		reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == $past(ctl_r);
	endproperty
	a_rd: assert property (p_rd) else $error("ctrl readback");
	// Read data must fall back to zero when no read was taken
	property p_rd_idle;
		vq_r && !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data stale");
	c_clamp: cover property (inc_o == 6'h0B);
	c_full: cover property (inc_o == 6'h30);
	c_carry: cover property (count_o[32]);
endmodule
`default_nettype wire

/* File: tb/spes_event_select_tb.sv */
// Self-checking bench for the event selector.
// Drives all event inputs from one vector, registers through tasks.
`timescale 1ns/100ps
`default_nettype none
module spes_event_select_tb;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [77:0] ev = '0;
	logic [47:0] count;
	logic [47:0] tot = 48'h0;
	logic [5:0]  inc;
	int          failures = 0;
	int          n_tests = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	spes_event_select spes_event_select_i (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .count_o(count), .inc_o(inc),
		.rx_bypass_pkt_i(ev[0]), .rx_standard_pkt_i(ev[1]),
		.rx_nondata_pkt_i(ev[2]), .rx_snoop_pkt_i(ev[3]),
		.tx_dataresp_pkt_i(ev[7:4]), .tx_dataresp_spawn_i(ev[11:8]),
		.tx_home_pkt_i(ev[13:12]), .tx_bypass_pkts_i(ev[29:14]),
		.tx_standard_pkts_i(ev[37:30]), .tx_nondata_pkt_i(ev[38]),
		.tx_snoop_pkt_i(ev[39]), .tx_snoop_spawn_i(ev[40]),
		.router_credit_in_i(ev[41]), .router_credit_out_i(ev[42]),
		.router_home_bypass_i(ev[43]), .router_snoop_bypass_i(ev[45:44]),
		.reqtbl_local_fill_i(ev[51:46]), .reqtbl_remote_fill_i(ev[57:52]),
		.ha_bypass_msg_i(ev[58]), .ha_bypass_credit_i(ev[59]),
		.ringq_ha_full_i(ev[60]), .ringq_ha_fill_i(ev[64:61]),
		.ringq_snoop_fill_i(ev[69:65]), .ringq_standard_fill_i(ev[72:70]),
		.ringq_bypass_fill_i(ev[75:73]), .ringq_nondata_full_i(ev[76]),
		.ringq_nondata_nonempty_i(ev[77]));
	function automatic [77:0] at(input int p, input [15:0] v);
		at = 78'(v) << p;
	endfunction
	task automatic chk(input string s, input [47:0] e, input [47:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wreg(input [7:0] a, input [31:0] v);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(input [7:0] a);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Five counted edges: three idle ones plus the two of the disabling write
	task automatic run(input [7:0] c, input [7:0] m, input [77:0] v, int e);
		@(posedge clk_sys_i);
		ev <= v;
		wreg(8'h00, {16'h0040, m, c});
		repeat (3) @(posedge clk_sys_i);
		#1 chk("inc", 48'(e), 48'(inc));
		wreg(8'h00, 32'h0);
		tot = tot + 48'(e) * 5;
		rreg(8'h04);
		chk("count lo", 48'(tot[31:0]), 48'(d));
		chk("count", tot, count);
		$display("test %h done", c);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		ev <= '1;
		rreg(8'h00);
		chk("ctrl reset", 48'h0, 48'(d));
		wreg(8'h00, 32'hFFFF_FF00);
		rreg(8'h00);
		chk("ctrl bits", 48'h40_FF00, 48'(d));
		wreg(8'h0C, 32'h0000_0001);
		rreg(8'h0C);
		chk("unknown code", 48'h0, 48'(d));
		rreg(8'h10);
		chk("unmapped", 48'h0, 48'(d));
		run(8'h75, 0, at(0, 1), 1);
		run(8'h74, 0, at(0, 3), 1);
		run(8'h70, 0, at(2, 1), 1);
		run(8'h71, 0, at(3, 1), 1);
		run(8'h64, 8'h05, at(4, 'h4F), 1);
		run(8'h64, 0, at(4, 'hF), 0);
		run(8'h60, 8'h01, at(12, 1), 1);
		run(8'h60, 8'h03, at(12, 3), 2);
		run(8'h68, 8'h0F, at(14, 'h0F0F), 11);
		run(8'h68, 8'h06, at(14, 'h0421), 6);
		run(8'h66, 8'h0F, at(30, 'hFF), 3);
		run(8'h63, 0, at(38, 1), 1);
		run(8'h62, 0, at(39, 3), 0);
		run(8'h62, 0, at(39, 1), 1);
		run(8'h76, 0, at(41, 1), 1);
		run(8'h6A, 0, at(42, 1), 1);
		run(8'h50, 0, at(43, 1), 1);
		run(8'h51, 8'h03, at(44, 3), 2);
		run(8'h31, 8'h03, at(46, 'hFFF), 48);
		run(8'h31, 8'h02, at(46, 'h0C5), 3);
		run(8'h52, 0, at(58, 2), 1);
		run(8'h52, 0, at(58, 1), 1);
		run(8'h2B, 0, at(60, 1), 1);
		run(8'h2D, 0, at(61, 3), 1);
		run(8'h26, 8'h05, at(65, 'h354), 23);
		run(8'h26, 8'h07, at(65, 'h7FF), 36);
		run(8'h21, 0, at(73, 4), 1);
		run(8'h24, 0, at(73, 1), 1);
		run(8'h22, 0, at(70, 4), 1);
		run(8'h27, 0, at(76, 1), 1);
		run(8'h28, 0, at(77, 1), 1);
		wreg(8'h04, 32'hFFFF_FFFE);
		wreg(8'h08, 32'h0);
		tot = 48'h0000_FFFF_FFFE;
		run(8'h2F, 0, at(61, 'hF), 8);
		rreg(8'h08);
		chk("count hi", 48'(tot[47:32]), 48'(d));
		summarize();
	end
endmodule
bind spes_event_select spes_checker #(.CNT_W(CNT_W)) spes_checker_i (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .count_o(count_o), .inc_o(inc_o));
`default_nettype wire
